// ===== hdl/dop_defines.vh
// Constants of the directional overpower protection element.
// Assumes inclusion by bare name from the design files.
`ifndef DOP_DEFINES_VH
`define DOP_DEFINES_VH

// ==========================================================
// Register byte offsets
`define DOP_OFS_CTRL       8'h00
`define DOP_OFS_PICKUP     8'h04
`define DOP_OFS_PWR_RATIO  8'h08
`define DOP_OFS_DO_RATIO   8'h0C
`define DOP_OFS_PU_DLY     8'h10
`define DOP_OFS_TRIP_DLY   8'h14
`define DOP_OFS_DO_DLY     8'h18
`define DOP_OFS_STATUS     8'h1C
`define DOP_OFS_IRQ_STS    8'h20
`define DOP_OFS_IRQ_MASK   8'h24
`define DOP_OFS_PU_CNT     8'h28
`define DOP_OFS_TRIP_CNT   8'h2C

// ==========================================================
// Control field positions
`define DOP_CTRL_ENABLE    0
`define DOP_CTRL_MODE_DT   1
`define DOP_CTRL_REACTIVE  2
`define DOP_CTRL_REVERSE   3
`define DOP_CTRL_BLK_LO    4
`define DOP_CTRL_BLK_HI    5

// Event bit positions (status and mask)
`define DOP_EV_PICKUP      0
`define DOP_EV_TRIP        1

// ==========================================================
// Reset values; power LSB is 0.001 of nominal apparent power
`define DOP_RST_PU_ACTIVE  16'h044C
`define DOP_RST_PU_REACT   16'h02BC
`define DOP_RST_PWR_RATIO  16'h0038
`define DOP_RST_DO_RATIO   7'h5F
`define DOP_RST_PU_DLY     10'h000
`define DOP_RST_TRIP_DLY   15'h0032
`define DOP_RST_DO_DLY     13'h0014

// Scale factors of the ratio compares
`define DOP_PQ_SCALE       16'h03E8
`define DOP_DO_SCALE       8'h64

// ==========================================================
// Timing: 1 ms base tick at 50 MHz, coarse tick of 10 base ticks
`define DOP_MS_CYCLES      16'hC350
`define DOP_COARSE_MS      4'hA

`endif

// ===== hdl/dop_timer.v
// Delay counter that advances on a tick while running.
// Assumes tick is a one-cycle pulse on the same clock.
module dop_timer #(
  parameter W = 16
) (
  input  wire         clk,    // System clock
  input  wire         srst,   // Sync reset, active high
  input  wire         ce,     // Clock enable
  input  wire         clr,    // Restart from zero
  input  wire         tick,   // Time base pulse
  input  wire [W-1:0] limit,  // Delay in ticks
  output wire         done    // Delay elapsed
);

  reg  [W-1:0] cnt_ff;
  reg  [W-1:0] nxt_cnt;

  assign done = (cnt_ff >= limit);

  always @*
  begin
    nxt_cnt = cnt_ff;
    if (clr)
      nxt_cnt = {W{1'b0}};
    else if (tick && !done)
      nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
  end

  always @(posedge clk)
  begin
    if (srst)
      cnt_ff <= {W{1'b0}};
    else if (ce)
      cnt_ff <= nxt_cnt;
  end

endmodule

// ===== hdl/dop_top.v
// Directional definite-time overpower element with APB registers.
// Assumes p_meas, q_meas and block_var come from logic on clk.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`include "dop_defines.vh"

// Summary of operation
// - Active variant picks up when active power exceeds the threshold.
// - It also picks up when the protected power exceeds ratio times the other.
// - Reactive variant picks up when reactive power exceeds the threshold.
// - Forward acts only on positive power, reverse only on negative power.
// - Both the global enable and definite-time mode are needed to operate.
// - Threshold 0.01 to 2.00 of nominal power, 1.10 active, 0.70 reactive.
// - Trip follows a trip delay of 0 to 300 s, default 0.5 s.
// - The fault must last a pickup delay up to 1000 ms before pickup.
// - Pickup holds for a drop-out delay of 0 to 60 s, default 0.2 s.
// - Pickup releases below threshold times drop-out ratio, def 0.95, or at once when not armed.
// - Pickup is blocked by none or one of three user variables.
// - A counter increments on every pickup assertion.
// - A separate counter increments on every trip assertion.
module dop_top #(
  parameter        REACTIVE_RST = 0,  // Variant after reset
  parameter [15:0] MS_CYCLES    =     // Cycles per 1 ms tick
    `DOP_MS_CYCLES
) (
  input  wire        clk,        // System clock, 50 MHz
  input  wire        srst,       // Sync reset, active high
  input  wire        ce,         // Clock enable
  input  wire        psel,       // APB select
  input  wire        penable,    // APB enable
  input  wire        pwrite,     // APB write
  input  wire [7:0]  paddr,      // APB byte address
  input  wire [31:0] pwdata,     // APB write data
  output reg  [31:0] prdata,     // APB read data
  output reg         pready,     // APB ready
  output reg         pslverr,    // APB error, unmapped
  input  wire [15:0] p_meas,     // Active power, signed
  input  wire [15:0] q_meas,     // Reactive power, signed
  input  wire [2:0]  block_var,  // User block variables
  output reg         pickup,     // Pickup output
  output reg         trip,       // Trip output
  output reg         irq         // Interrupt, level
);

  // ========================================================
  // State encoding
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_PUW  = 4'h2;
  localparam [3:0] ST_PICK = 4'h4;
  localparam [3:0] ST_DROP = 4'h8;

  // ========================================================
  // Registers
  reg  [5:0]  ctrl_ff;
  reg  [15:0] thr_ff;
  reg  [15:0] pq_ff;
  reg  [6:0]  dor_ff;
  reg  [9:0]  pu_dly_ff;
  reg  [14:0] trip_dly_ff;
  reg  [12:0] do_dly_ff;
  reg  [1:0]  irq_sts_ff;
  reg  [1:0]  irq_msk_ff;
  reg  [15:0] pu_cnt_ff;
  reg  [15:0] trip_cnt_ff;
  reg  [3:0]  st_ff;
  reg  [3:0]  nxt_st;
  reg  [15:0] ms_cnt_ff;
  reg  [3:0]  co_cnt_ff;
  reg         ms_tick_ff;
  reg         co_tick_ff;
  reg         nxt_trip;
  reg  [31:0] rd_data;
  reg         rd_err;

  wire acc    = psel && penable;
  wire wr_en  = acc && pwrite && pready;
  wire [1:0] w1c = (wr_en && paddr == `DOP_OFS_IRQ_STS) ?
                   pwdata[1:0] : 2'h0;

  // ========================================================
  // Directional magnitudes
  wire        reactive = ctrl_ff[`DOP_CTRL_REACTIVE];
  wire        reverse  = ctrl_ff[`DOP_CTRL_REVERSE];
  wire [15:0] prot = reactive ? q_meas : p_meas;
  wire [15:0] oth  = reactive ? p_meas : q_meas;
  wire [16:0] prot_n = 17'h00000 - {prot[15], prot};
  wire [16:0] oth_n  = 17'h00000 - {oth[15], oth};
  wire        pos  = !prot[15] && (prot != 16'h0000);
  wire [15:0] v_mag = (!reverse && pos) ? prot :
                      (reverse && prot[15]) ? prot_n[15:0] : 16'h0000;
  wire [15:0] o_mag = oth[15] ? oth_n[15:0] : oth;

  // ========================================================
  // Operate and hold conditions
  wire [31:0] v_pq  = {16'h0000, v_mag} * {16'h0000, `DOP_PQ_SCALE};
  wire [31:0] o_pq  = {16'h0000, o_mag} * {16'h0000, pq_ff};
  wire        pq_op = v_pq > o_pq;
  wire        thr_op = v_mag > thr_ff;
  wire        op    = thr_op || pq_op;
  wire [23:0] v_do  = {8'h00, v_mag} * {16'h0000, `DOP_DO_SCALE};
  wire [23:0] t_do  = {8'h00, thr_ff} * {17'h00000, dor_ff};
  wire        hold  = (v_do >= t_do) || pq_op;

  reg blocked;
  always @*
  begin
    case (ctrl_ff[`DOP_CTRL_BLK_HI:`DOP_CTRL_BLK_LO])
      2'h1:    blocked = block_var[0];
      2'h2:    blocked = block_var[1];
      2'h3:    blocked = block_var[2];
      default: blocked = 1'b0;
    endcase
  end

  wire armed = ctrl_ff[`DOP_CTRL_ENABLE] &&
               ctrl_ff[`DOP_CTRL_MODE_DT] && !blocked;

  // ========================================================
  // Time base: 1 ms and 10 ms ticks
  always @(posedge clk)
  begin
    if (srst)
    begin
      ms_cnt_ff  <= 16'h0000;
      co_cnt_ff  <= 4'h0;
      ms_tick_ff <= 1'b0;
      co_tick_ff <= 1'b0;
    end
    else if (ce)
    begin
      ms_tick_ff <= (ms_cnt_ff == MS_CYCLES - 16'h0001);
      co_tick_ff <= ms_tick_ff &&
                    (co_cnt_ff == `DOP_COARSE_MS - 4'h1);
      if (ms_cnt_ff == MS_CYCLES - 16'h0001)
        ms_cnt_ff <= 16'h0000;
      else
        ms_cnt_ff <= ms_cnt_ff + 16'h0001;
      if (ms_tick_ff)
      begin
        if (co_cnt_ff == `DOP_COARSE_MS - 4'h1)
          co_cnt_ff <= 4'h0;
        else
          co_cnt_ff <= co_cnt_ff + 4'h1;
      end
    end
  end

  // ========================================================
  // Delay timers
  wire pu_done;
  wire trip_done;
  wire do_done;
  wire picked = (st_ff == ST_PICK) || (st_ff == ST_DROP);

  dop_timer #(.W(10)) u_pu_tmr (
    .clk   (clk),
    .srst  (srst),
    .ce    (ce),
    .clr   (!armed || st_ff != ST_PUW),
    .tick  (ms_tick_ff),
    .limit (pu_dly_ff),
    .done  (pu_done)
  );

  dop_timer #(.W(15)) u_trip_tmr (
    .clk   (clk),
    .srst  (srst),
    .ce    (ce),
    .clr   (!armed || !picked),
    .tick  (co_tick_ff),
    .limit (trip_dly_ff),
    .done  (trip_done)
  );

  dop_timer #(.W(13)) u_do_tmr (
    .clk   (clk),
    .srst  (srst),
    .ce    (ce),
    .clr   (!armed || st_ff != ST_DROP),
    .tick  (co_tick_ff),
    .limit (do_dly_ff),
    .done  (do_done)
  );

  // ========================================================
  // Pickup state machine
  always @*
  begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE:
        if (op)
          nxt_st = ST_PUW;
      ST_PUW:
        if (!op)
          nxt_st = ST_IDLE;
        else if (pu_done)
          nxt_st = ST_PICK;
      ST_PICK:
        if (!hold)
          nxt_st = ST_DROP;
      ST_DROP:
        if (hold)
          nxt_st = ST_PICK;
        else if (do_done)
          nxt_st = ST_IDLE;
      default:
        nxt_st = ST_IDLE;
    endcase
    if (!armed)
      nxt_st = ST_IDLE;
  end

  wire nxt_pick = (nxt_st == ST_PICK) || (nxt_st == ST_DROP);

  always @*
  begin
    nxt_trip = nxt_pick && (trip || (picked && trip_done));
  end

  wire pu_rise   = nxt_pick && !pickup;
  wire trip_rise = nxt_trip && !trip;
  wire [1:0] ev  = {trip_rise, pu_rise};
  wire [1:0] nxt_sts = ev | (irq_sts_ff & ~w1c);

  always @(posedge clk)
  begin
    if (srst)
    begin
      st_ff       <= ST_IDLE;
      pickup      <= 1'b0;
      trip        <= 1'b0;
      irq_sts_ff  <= 2'h0;
      irq         <= 1'b0;
      pu_cnt_ff   <= 16'h0000;
      trip_cnt_ff <= 16'h0000;
    end
    else if (ce)
    begin
      st_ff      <= nxt_st;
      pickup     <= nxt_pick;
      trip       <= nxt_trip;
      irq_sts_ff <= nxt_sts;
      irq        <= |(nxt_sts & irq_msk_ff);
      if (pu_rise)
        pu_cnt_ff <= pu_cnt_ff + 16'h0001;
      else if (wr_en && paddr == `DOP_OFS_PU_CNT)
        pu_cnt_ff <= 16'h0000;
      if (trip_rise)
        trip_cnt_ff <= trip_cnt_ff + 16'h0001;
      else if (wr_en && paddr == `DOP_OFS_TRIP_CNT)
        trip_cnt_ff <= 16'h0000;
    end
  end

  // ========================================================
  // APB settings write
  always @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_ff     <= REACTIVE_RST ? 6'h04 : 6'h00;
      thr_ff      <= REACTIVE_RST ? `DOP_RST_PU_REACT :
                                    `DOP_RST_PU_ACTIVE;
      pq_ff       <= `DOP_RST_PWR_RATIO;
      dor_ff      <= `DOP_RST_DO_RATIO;
      pu_dly_ff   <= `DOP_RST_PU_DLY;
      trip_dly_ff <= `DOP_RST_TRIP_DLY;
      do_dly_ff   <= `DOP_RST_DO_DLY;
      irq_msk_ff  <= 2'h0;
    end
    else if (ce && wr_en)
    begin
      if (paddr == `DOP_OFS_CTRL)
        ctrl_ff <= pwdata[5:0];
      else if (paddr == `DOP_OFS_PICKUP)
        thr_ff <= pwdata[15:0];
      else if (paddr == `DOP_OFS_PWR_RATIO)
        pq_ff <= pwdata[15:0];
      else if (paddr == `DOP_OFS_DO_RATIO)
        dor_ff <= pwdata[6:0];
      else if (paddr == `DOP_OFS_PU_DLY)
        pu_dly_ff <= pwdata[9:0];
      else if (paddr == `DOP_OFS_TRIP_DLY)
        trip_dly_ff <= pwdata[14:0];
      else if (paddr == `DOP_OFS_DO_DLY)
        do_dly_ff <= pwdata[12:0];
      else if (paddr == `DOP_OFS_IRQ_MASK)
        irq_msk_ff <= pwdata[1:0];
    end
  end

  // ========================================================
  // APB read decode
  always @*
  begin
    rd_data = 32'h00000000;
    rd_err  = 1'b0;
    if (paddr == `DOP_OFS_CTRL)
      rd_data = {26'h0000000, ctrl_ff};
    else if (paddr == `DOP_OFS_PICKUP)
      rd_data = {16'h0000, thr_ff};
    else if (paddr == `DOP_OFS_PWR_RATIO)
      rd_data = {16'h0000, pq_ff};
    else if (paddr == `DOP_OFS_DO_RATIO)
      rd_data = {25'h0000000, dor_ff};
    else if (paddr == `DOP_OFS_PU_DLY)
      rd_data = {22'h000000, pu_dly_ff};
    else if (paddr == `DOP_OFS_TRIP_DLY)
      rd_data = {17'h00000, trip_dly_ff};
    else if (paddr == `DOP_OFS_DO_DLY)
      rd_data = {19'h00000, do_dly_ff};
    else if (paddr == `DOP_OFS_STATUS)
      rd_data = {28'h0000000, blocked, op, trip, pickup};
    else if (paddr == `DOP_OFS_IRQ_STS)
      rd_data = {30'h00000000, irq_sts_ff};
    else if (paddr == `DOP_OFS_IRQ_MASK)
      rd_data = {30'h00000000, irq_msk_ff};
    else if (paddr == `DOP_OFS_PU_CNT)
      rd_data = {16'h0000, pu_cnt_ff};
    else if (paddr == `DOP_OFS_TRIP_CNT)
      rd_data = {16'h0000, trip_cnt_ff};
    else
      rd_err = 1'b1;
  end

  // One wait state: ready rises in the second access cycle
  always @(posedge clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end
    else if (ce)
    begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && rd_err;
      if (acc && !pready && !pwrite)
        prdata <= rd_data;
    end
  end

endmodule

// ===== tb/dop_sva.sv
// Port assertions for the overpower element.
// Assumes binding to dop_top, with ce held high.
module dop_sva (
  input logic        clk,      // Clock
  input logic        srst,     // Sync reset
  input logic        psel,     // APB select
  input logic        penable,  // APB enable
  input logic        pwrite,   // APB write
  input logic [7:0]  paddr,    // APB address
  input logic [31:0] prdata,   // APB read data
  input logic        pready,   // APB ready
  input logic        pslverr,  // APB error
  input logic        pickup,   // Pickup out
  input logic        trip,     // Trip out
  input logic        irq       // Interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // Reset state and bus answer
  a_reset_quiet: assert property ($fell(srst) |-> !pickup && !trip && !irq)
    else $error("output high after reset");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("ready not in second access cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_unmapped: assert property (pready && paddr > 8'h2C |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (pready && paddr <= 8'h2C &&
    paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  a_err_rdata: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0)
    else $error("read data not zero on error");
  // ==========================================================
  // Protection outputs
  a_trip_after_pu: assert property ($rose(trip) |-> $past(pickup))
    else $error("trip without pickup");
  a_trip_clears: assert property (!pickup |=> !trip)
    else $error("trip held after pickup drop");
endmodule

bind dop_top dop_sva u_sva (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pickup(pickup), .trip(trip), .irq(irq)
);

// ===== tb/dop_meas_model.sv
// Behavioural power measurement front end feeding P and Q.
// Assumes commands from the bench on the same clock.
module dop_meas_model (
  input  logic        clk,               // Sampling clock
  input  logic [15:0] p_cmd,             // Wanted active power
  input  logic [15:0] q_cmd,             // Wanted reactive power
  output logic [15:0] p_meas = 16'h0000, // Active power sample
  output logic [15:0] q_meas = 16'h0000  // Reactive power sample
);
  // One sample of latency
  always @(posedge clk)
  begin
    p_meas <= p_cmd;
    q_meas <= q_cmd;
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the overpower element.
// Assumes a 1 ms tick of 10 cycles and the APB map of the defines.
`include "dop_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_data;
  logic        pready, pslverr, pickup, trip, irq, rd_err;
  logic [15:0] p_cmd = 16'h0000;
  logic [15:0] q_cmd = 16'h03E8;
  logic [15:0] p_meas, q_meas;
  logic [2:0]  block_var = 3'h0;
  int          errors = 0;
  int          checks_done = 0;

  always #10 clk = ~clk;

  dop_meas_model fe (.clk(clk), .p_cmd(p_cmd), .q_cmd(q_cmd),
    .p_meas(p_meas), .q_meas(q_meas));
  dop_top #(.MS_CYCLES(16'h000A)) dut (.clk(clk), .srst(srst), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .p_meas(p_meas), .q_meas(q_meas), .block_var(block_var),
    .pickup(pickup), .trip(trip), .irq(irq));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hang
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_data, exp);
  endtask

  task automatic go(input logic [15:0] p, input int n, input logic e);
    p_cmd <= p;
    repeat (n) @(posedge clk);
    chk({31'h0, pickup}, {31'h0, e});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] exp [7];
    exp = '{32'h0, 32'h44C, 32'h38, 32'h5F, 32'h0, 32'h32, 32'h14};
    for (int i = 0; i < 7; i++)
      rdc(8'(4 * i), exp[i]);
    rdc(`DOP_OFS_IRQ_MASK, 32'h0);
    rdc(8'h30, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
  endtask

  task automatic t_thresh;
    xfer(1'b1, `DOP_OFS_PWR_RATIO, 32'hFFFF);
    xfer(1'b1, `DOP_OFS_DO_DLY, 32'h0);
    xfer(1'b1, `DOP_OFS_TRIP_DLY, 32'h5);
    xfer(1'b1, `DOP_OFS_IRQ_MASK, 32'h1);
    xfer(1'b1, `DOP_OFS_CTRL, 32'h3);
    go(16'h044C, 20, 1'b0);
    go(16'h044D, 20, 1'b1);
    chk({31'h0, irq}, 32'h1);
    go(16'h041A, 20, 1'b1);
    go(16'h0414, 20, 1'b0);
    rdc(`DOP_OFS_PU_CNT, 32'h1);
    xfer(1'b1, `DOP_OFS_IRQ_STS, 32'h3);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask

  task automatic t_trip;
    go(16'h04B0, 350, 1'b1);
    chk({31'h0, trip}, 32'h0);
    repeat (300) @(posedge clk);
    chk({31'h0, trip}, 32'h1);
    rdc(`DOP_OFS_STATUS, 32'h7);
    rdc(`DOP_OFS_IRQ_STS, 32'h3);
    chk({31'h0, irq}, 32'h1);
    go(16'h0000, 20, 1'b0);
    chk({31'h0, trip}, 32'h0);
    rdc(`DOP_OFS_TRIP_CNT, 32'h1);
    rdc(`DOP_OFS_PU_CNT, 32'h2);
    xfer(1'b1, `DOP_OFS_PU_CNT, 32'h0);
    rdc(`DOP_OFS_PU_CNT, 32'h0);
    xfer(1'b1, `DOP_OFS_TRIP_CNT, 32'h0);
    rdc(`DOP_OFS_TRIP_CNT, 32'h0);
  endtask

  task automatic t_dir_enable;
    xfer(1'b1, `DOP_OFS_CTRL, 32'hB);
    go(16'h04B0, 20, 1'b0);
    go(16'hFB50, 20, 1'b1);
    go(16'h0000, 20, 1'b0);
    xfer(1'b1, `DOP_OFS_CTRL, 32'h1);
    go(16'h04B0, 20, 1'b0);
    xfer(1'b1, `DOP_OFS_CTRL, 32'h2);
    go(16'h04B0, 20, 1'b0);
    xfer(1'b1, `DOP_OFS_CTRL, 32'h3);
    go(16'h04B0, 20, 1'b1);
  endtask

  task automatic t_block;
    xfer(1'b1, `DOP_OFS_CTRL, 32'h23);
    go(16'h04B0, 20, 1'b1);
    block_var <= 3'h1;
    go(16'h04B0, 10, 1'b1);
    block_var <= 3'h2;
    go(16'h04B0, 4, 1'b0);
    rdc(`DOP_OFS_STATUS, 32'hC);
    block_var <= 3'h3;
    xfer(1'b1, `DOP_OFS_CTRL, 32'h33);
    go(16'h04B0, 20, 1'b1);
    block_var <= 3'h4;
    go(16'h04B0, 4, 1'b0);
    xfer(1'b1, `DOP_OFS_CTRL, 32'h13);
    go(16'h04B0, 20, 1'b1);
    block_var <= 3'h1;
    go(16'h04B0, 4, 1'b0);
    block_var <= 3'h0;
    go(16'h0000, 20, 1'b0);
  endtask

  task automatic t_delays;
    xfer(1'b1, `DOP_OFS_PU_DLY, 32'h5);
    go(16'h04B0, 20, 1'b0);
    go(16'h0000, 5, 1'b0);
    go(16'h04B0, 30, 1'b0);
    go(16'h04B0, 60, 1'b1);
    xfer(1'b1, `DOP_OFS_DO_DLY, 32'h2);
    go(16'h0000, 80, 1'b1);
    go(16'h0000, 250, 1'b0);
    xfer(1'b1, `DOP_OFS_DO_DLY, 32'h0);
    xfer(1'b1, `DOP_OFS_PU_DLY, 32'h0);
  endtask

  task automatic t_ratio_react;
    xfer(1'b1, `DOP_OFS_PWR_RATIO, 32'h38);
    go(16'h01F4, 20, 1'b1);
    xfer(1'b1, `DOP_OFS_PWR_RATIO, 32'h200);
    go(16'h01F4, 20, 1'b0);
    xfer(1'b1, `DOP_OFS_PWR_RATIO, 32'hFFFF);
    xfer(1'b1, `DOP_OFS_IRQ_MASK, 32'h0);
    xfer(1'b1, `DOP_OFS_IRQ_STS, 32'h3);
    xfer(1'b1, `DOP_OFS_CTRL, 32'h7);
    q_cmd <= 16'h04B0;
    go(16'h03E8, 20, 1'b1);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `DOP_OFS_IRQ_MASK, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    q_cmd <= 16'h03E8;
    go(16'h04B0, 20, 1'b0);
  endtask

  task automatic tally_and_finish;
    $display("checks_done=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog, about three and a half times the expected run
  initial
  begin
    repeat (6000) @(posedge clk);
    errors++;
    $display("FAIL t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish;
  end

  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_thresh;
    t_trip;
    t_dir_enable;
    t_block;
    t_delays;
    t_ratio_react;
    tally_and_finish;
  end
endmodule
